/* File: testbench/pcg_pll_model.sv */
// behavioural pll that answers retunes with a lock report
`timescale 1ns/1ps
`default_nettype none

module pcg_pll_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] pll_mult,
    input  wire logic       slow,
    output var  logic       pll_locked
);
    logic [3:0] last_mult = 4'hD;
    int         wait_cnt = 0;

    // ----------------
    // lock behaviour
    // ----------------
    // lock drops at once on a retune; slow mode models a long acquisition
    initial pll_locked = 1'b1;
    always @(posedge clk_sys) begin
        if (pll_mult != last_mult) begin
            last_mult  <= pll_mult;
            pll_locked <= 1'b0;
            wait_cnt   <= slow ? 300 : 20;
        end else if (wait_cnt > 0) begin
            wait_cnt   <= wait_cnt - 1;
            pll_locked <= wait_cnt == 1;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/pcg_properties.sv */
// assertion checker for the clock generation control block
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"

module pcg_properties (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        variant_pll,
    input wire logic        pll_locked,
    input wire logic [3:0]  pll_mult,
    input wire logic        dbl_en,
    input wire logic [1:0]  spread_mode,
    input wire logic        core_clk_en
);
    localparam int SETTLE = `PCG_SETTLE_CYC;
    int   lock_cnt;
    logic relock;
    wire  mapped = paddr == `PCG_OFF_CTRL || paddr == `PCG_OFF_STATUS
                   || paddr == `PCG_OFF_FREQ;

    // ----------------
    // helper logic
    // ----------------
    // lock run length; a retune stays pending until the clock returns
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lock_cnt <= 0;
            relock   <= 1'b0;
        end else begin
            lock_cnt <= pll_locked ? lock_cnt + 1 : 0;
            relock   <= $changed(pll_mult) || (relock && !core_clk_en);
        end
    end

    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_access;
        psel && penable;
    endsequence
    sequence s_retune;
        variant_pll && $changed(pll_mult);
    endsequence
    sequence s_clk_held;
        !core_clk_en [*8];
    endsequence

    property p_ready;
        s_access |-> pready && pslverr == !mapped;
    endproperty
    property p_rd_zero;
        s_access and !pwrite && !mapped |-> prdata == 32'h0;
    endproperty
    property p_mult_rng;
        pll_mult >= `PCG_MULT_MIN && pll_mult <= `PCG_MULT_MAX;
    endproperty
    property p_spr_code;
        spread_mode != 2'h3;
    endproperty
    property p_dbl_off;
        variant_pll && core_clk_en |-> !dbl_en;
    endproperty
    property p_reset_val;
        $rose(resetn) |-> pll_mult == `PCG_MULT_RESET
                          && spread_mode == `PCG_SPR_RESET;
    endproperty
    property p_retune_off;
        s_retune |-> s_clk_held;
    endproperty
    property p_relock_wait;
        variant_pll && relock && $rose(core_clk_en) |-> lock_cnt >= SETTLE;
    endproperty

    a_ready: assert property (p_ready)
        else $error("bad ready or error flag");
    a_rd_zero: assert property (p_rd_zero)
        else $error("unmapped read not zero");
    a_mult_rng: assert property (p_mult_rng)
        else $error("multiple out of range");
    a_spr_code: assert property (p_spr_code)
        else $error("spreader code 3 driven");
    a_dbl_off: assert property (p_dbl_off)
        else $error("doubler on in pll variant");
    a_reset_val: assert property (p_reset_val)
        else $error("wrong values after reset");
    a_retune_off: assert property (p_retune_off)
        else $error("core clock on during relock");
    a_relock_wait: assert property (p_relock_wait)
        else $error("core clock back before settle");
endmodule

bind pcg_top pcg_properties i_pcg_properties (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .variant_pll(variant_pll),
    .pll_locked(pll_locked), .pll_mult(pll_mult), .dbl_en(dbl_en),
    .spread_mode(spread_mode), .core_clk_en(core_clk_en));
`default_nettype wire

/* File: testbench/tb_processor_clock_generation.sv */
// self-checking testbench for the clock generation control block
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"

module tb_processor_clock_generation;
    logic        clk_sys, resetn, psel, penable, pwrite, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ctl, st;
    logic        pready, pslverr, variant_pll, pll_locked;
    logic [3:0]  pll_mult, m;
    logic        dbl_en, core_clk_en;
    logic [1:0]  spread_mode;
    logic [32:0] exp_q[$];
    int          n_fail = 0;
    int          checked = 0;
    int          cycles = 0;
    integer      seed = 32'hF84A5399;

    pcg_top i_pcg_top (
        .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .variant_pll(variant_pll),
        .pll_locked(pll_locked), .pll_mult(pll_mult), .dbl_en(dbl_en),
        .spread_mode(spread_mode), .core_clk_en(core_clk_en));
    pcg_pll_model i_pcg_pll_model (.clk_sys(clk_sys), .pll_mult(pll_mult),
        .slow(slow), .pll_locked(pll_locked));

    // ----------------
    // clock, limit, checking
    // ----------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // the tests need under 20000 cycles, so double that means a hang
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        checked = checked + 1;
        if (seen !== want) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // each completed access is paired with the oldest expectation
    always @(posedge clk_sys) begin
        if (resetn && psel && penable && pready === 1'b1)
            chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    end

    // ----------------
    // bus and sequence tasks
    // ----------------
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        exp_q.push_back(e);
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    // two edges first so the drop of the core clock has landed
    task automatic wait_run();
        int n;
        n = 0;
        repeat (2) @(posedge clk_sys);
        while (core_clk_en !== 1'b1 && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
        chk({32'h0, core_clk_en}, 33'h1);
    endtask
    task automatic rst(input logic v);
        resetn      <= 1'b0;
        variant_pll <= v;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask

    // ----------------
    // main sequence
    // ----------------
    initial begin
        {resetn, psel, penable, pwrite, slow, variant_pll} = 6'h01;
        paddr = 12'h000;
        pwdata = 32'h0;
        rst(1'b1);
        rd(`PCG_OFF_CTRL, 32'h0000011D);
        rd(`PCG_OFF_FREQ, 32'h00027AC4);
        rd(`PCG_OFF_STATUS, 32'h0000060D);
        chk({30'h0, dbl_en, spread_mode}, 33'h0);
        $display("test reset values done");
        // random multiples, spreader codes 0 to 2, prompt and slow locks
        for (int i = 0; i < 6; i++) begin
            m = 4'h2 + 4'({$random(seed)} % 12);
            slow <= 1'($random(seed));
            ctl = {23'h0, 1'b1, 2'h0, 2'(i % 3), m};
            st = {21'h0, 2'h3, 3'h0, ctl[5:0]};
            wr(`PCG_OFF_CTRL, ctl);
            wait_run();
            rd(`PCG_OFF_STATUS, st);
            rd(`PCG_OFF_FREQ, 32'(m) * 32'h30D4);
            chk({27'h0, spread_mode, pll_mult}, {27'h0, ctl[5:0]});
        end
        // networking-grade setting: 100 MHz with normal spreading
        ctl = 32'h00000118;
        st  = 32'h00000618;
        wr(`PCG_OFF_CTRL, ctl);
        wait_run();
        rd(`PCG_OFF_FREQ, 32'h000186A0);
        $display("test retune done");
        wr(`PCG_OFF_CTRL, 32'h0000010E);
        wr(`PCG_OFF_CTRL, 32'h00000101);
        wr(`PCG_OFF_CTRL, 32'h0000013D);
        rd(`PCG_OFF_CTRL, ctl);
        rd(`PCG_OFF_STATUS, st | 32'h00010000);
        wr(`PCG_OFF_STATUS, 32'hFFFFFFFF);
        rd(`PCG_OFF_STATUS, st);
        apb(1'b1, 12'h00C, 32'hFFFFFFFF, 33'h100000000);
        apb(1'b0, 12'hFFC, 32'h0, 33'h100000000);
        rd(`PCG_OFF_CTRL, ctl);
        $display("test refusals done");
        rst(1'b0);
        rd(`PCG_OFF_FREQ, 32'h00012000);
        chk({30'h0, dbl_en, spread_mode}, 33'h5);
        wr(`PCG_OFF_CTRL, 32'h0000000D);
        rd(`PCG_OFF_FREQ, 32'h00009000);
        chk({30'h0, dbl_en, spread_mode}, 33'h0);
        wr(`PCG_OFF_CTRL, 32'h0000011D);
        rd(`PCG_OFF_CTRL, 32'h0000011D);
        chk({30'h0, dbl_en, spread_mode}, 33'h5);
        $display("test doubler done");
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: verilog/pcg_consts.vh */
// constants for the processor clock generation block
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH

// ------------------------------------------------------------------
// register offsets (byte addresses on the apb bus)
// ------------------------------------------------------------------
`define PCG_OFF_CTRL        12'h000
`define PCG_OFF_STATUS      12'h004
`define PCG_OFF_FREQ        12'h008

// ------------------------------------------------------------------
// control field layout and reset values
// ------------------------------------------------------------------
`define PCG_CTRL_MULT_LSB   0
`define PCG_CTRL_MULT_MSB   3
`define PCG_CTRL_SPR_LSB    4
`define PCG_CTRL_SPR_MSB    5
`define PCG_CTRL_DBL_BIT    8
`define PCG_MULT_RESET      4'hD
`define PCG_SPR_RESET       2'h1
`define PCG_DBL_RESET       1'b1

// ------------------------------------------------------------------
// status field layout
// ------------------------------------------------------------------
`define PCG_ST_BUSY_BIT     8
`define PCG_ST_LOCK_BIT     9
`define PCG_ST_VAR_BIT      10
`define PCG_ST_BADSEL_BIT   16

// ------------------------------------------------------------------
// frequency plan: multiples of the 12.5 MHz step, and the crystal, in kHz
// ------------------------------------------------------------------
`define PCG_STEP_KHZ        32'h000030D4
`define PCG_MULT_MIN        4'h2
`define PCG_MULT_MAX        4'hD
`define PCG_XTAL_KHZ        32'h00009000
`define PCG_SLOW_MAX_MULT   4'h8

// ------------------------------------------------------------------
// spreader strength codes
// ------------------------------------------------------------------
`define PCG_SPR_OFF         2'h0
`define PCG_SPR_NORMAL      2'h1
`define PCG_SPR_STRONG      2'h2
`define PCG_SPR_BAD         2'h3

// ------------------------------------------------------------------
// timing: settle time after a lock report, and clock rate
// ------------------------------------------------------------------
`define PCG_CLK_MHZ         200
`define PCG_SETTLE_US       10
`define PCG_SETTLE_CYC      (`PCG_SETTLE_US * `PCG_CLK_MHZ)

`endif

/* File: verilog/pcg_lock_wait.v */
// relock settle timer for the processor clock generation block
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"

module pcg_lock_wait (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        start,
    input  wire        lock_s,
    output reg         done
);

    localparam integer SETTLE_LAST_INT = `PCG_SETTLE_CYC - 1;
    localparam [11:0]  SETTLE_LAST     = SETTLE_LAST_INT[11:0];

    reg        armed;
    reg [11:0] count;

    // ------------------------------------------------------------------
    // settle counter
    // ------------------------------------------------------------------
    // lock must stand unbroken for the whole settle time; any drop
    // restarts the count so a glitchy lock indication never commits
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            armed <= 1'b0;
            count <= 12'h000;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                armed <= 1'b1;
                count <= 12'h000;
            end else if (armed) begin
                if (!lock_s) begin
                    count <= 12'h000;
                end else if (count == SETTLE_LAST) begin
                    armed <= 1'b0;
                    done  <= 1'b1;   // relocked and settled
                end else begin
                    count <= count + 12'h001;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: verilog/pcg_top.v */
// processor clock generation control with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"

module pcg_top (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        variant_pll,
    input  wire        pll_locked,
    output reg  [3:0]  pll_mult,
    output reg         dbl_en,
    output reg  [1:0]  spread_mode,
    output reg         core_clk_en
);

    // ------------------------------------------------------------------
    // state codes of the relock sequencer
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_RELOCK = 3'b010;
    localparam [2:0] ST_COMMIT = 3'b100;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [3:0]  req_mult;        // software selection, held
    reg  [1:0]  req_spr;
    reg         req_dbl;
    reg         spr_written;     // spreader chosen explicitly
    reg  [3:0]  act_mult;        // applied selection
    reg  [1:0]  act_spr;
    reg         bad_sel;
    reg         var_meta;
    reg         var_sync;
    reg         lock_meta;
    reg         lock_sync;
    reg  [1:0]  sync_fill;       // marks both stages loaded
    reg         strap_taken;
    reg         is_pll;
    reg         relock_start;
    wire        relock_done;
    wire        wr_en;
    wire        rd_en;
    wire        hit_ctrl;
    wire        hit_status;
    wire        hit_freq;
    wire        mapped;
    wire [3:0]  wr_mult;
    wire [1:0]  wr_spr;
    wire        mult_ok;
    wire        spr_ok;
    wire        sel_ok;
    wire        pending;
    reg  [1:0]  eff_spr;
    reg  [31:0] freq_khz;
    reg  [31:0] rd_mux;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // the slave never stalls, so every access ends in its first
    // access-phase cycle; unmapped addresses answer with an error
    assign wr_en      = psel & penable & pwrite;
    assign rd_en      = psel & ~pwrite;
    assign hit_ctrl   = (paddr == `PCG_OFF_CTRL);
    assign hit_status = (paddr == `PCG_OFF_STATUS);
    assign hit_freq   = (paddr == `PCG_OFF_FREQ);
    assign mapped     = hit_ctrl | hit_status | hit_freq;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~mapped;

    // ------------------------------------------------------------------
    // selection check
    // ------------------------------------------------------------------
    // only whole steps inside the legal range are taken; anything else
    // leaves the stored selection alone and raises a sticky flag
    assign wr_mult = pwdata[`PCG_CTRL_MULT_MSB:`PCG_CTRL_MULT_LSB];
    assign wr_spr  = pwdata[`PCG_CTRL_SPR_MSB:`PCG_CTRL_SPR_LSB];
    assign mult_ok = (wr_mult >= `PCG_MULT_MIN) &&
                     (wr_mult <= `PCG_MULT_MAX);
    assign spr_ok  = (wr_spr != `PCG_SPR_BAD);
    assign sel_ok  = mult_ok & spr_ok;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // both pins come from outside the clock domain
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            var_meta  <= 1'b0;
            var_sync  <= 1'b0;
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            sync_fill <= 2'h0;
        end else begin
            var_meta  <= variant_pll;
            var_sync  <= var_meta;
            lock_meta <= pll_locked;
            lock_sync <= lock_meta;
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    // ------------------------------------------------------------------
    // variant strap
    // ------------------------------------------------------------------
    // caught once, when both stages hold the pin; reading the first
    // stage would let a metastable value decide the variant
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            strap_taken <= 1'b0;
            is_pll      <= 1'b0;
        end else if (!strap_taken && sync_fill[1]) begin
            strap_taken <= 1'b1;
            is_pll      <= var_sync;
        end
    end

    // ------------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------------
    // writes land here at once; the pll gets pll_mult as a relock starts, the spreader after it
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            req_mult    <= `PCG_MULT_RESET;
            req_spr     <= `PCG_SPR_RESET;
            req_dbl     <= `PCG_DBL_RESET;
            spr_written <= 1'b0;
        end else if (wr_en && hit_ctrl && sel_ok) begin
            req_mult    <= wr_mult;
            req_spr     <= wr_spr;
            req_dbl     <= pwdata[`PCG_CTRL_DBL_BIT];
            spr_written <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // sticky bad selection flag
    // ------------------------------------------------------------------
    // write one to clear; a fresh bad write in the same cycle wins
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bad_sel <= 1'b0;
        end else if (wr_en && hit_ctrl && !sel_ok) begin
            bad_sel <= 1'b1;
        end else if (wr_en && hit_status &&
                     pwdata[`PCG_ST_BADSEL_BIT]) begin
            bad_sel <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // relock sequencer
    // ------------------------------------------------------------------
    // the doubler variant has no pll to relock, so its selection
    // is not stepped through here; only the pll variant waits
    assign pending = is_pll && strap_taken &&
                     ((req_mult != act_mult) || (req_spr != act_spr));

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (pending) begin
                    next_state = ST_RELOCK;
                end
            end
            ST_RELOCK: begin
                if (relock_done) begin
                    next_state = ST_COMMIT;
                end
            end
            ST_COMMIT: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state        <= ST_IDLE;
            relock_start <= 1'b0;
            pll_mult     <= `PCG_MULT_RESET;
            act_mult     <= `PCG_MULT_RESET;
            act_spr      <= `PCG_SPR_RESET;
            core_clk_en  <= 1'b0;
        end else begin
            state        <= next_state;
            relock_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // core follows the lock on the pll variant, and runs once the strap is taken on the doubler
                    core_clk_en <= is_pll ? lock_sync : strap_taken;
                    if (!is_pll) begin
                        act_mult <= req_mult;   // doubler applies at once
                        act_spr  <= req_spr;
                    end
                    if (pending) begin
                        pll_mult     <= req_mult;
                        relock_start <= 1'b1;
                        core_clk_en  <= 1'b0;   // hold core off the slew
                    end
                end
                ST_RELOCK: begin
                    core_clk_en <= 1'b0;
                end
                ST_COMMIT: begin
                    act_mult    <= pll_mult;
                    act_spr     <= req_spr;
                    core_clk_en <= 1'b1;
                end
                default: begin
                    core_clk_en <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // settle timer
    // ------------------------------------------------------------------
    pcg_lock_wait u_lock_wait (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .start   (relock_start),
        .lock_s  (lock_sync),
        .done    (relock_done)
    );

    // ------------------------------------------------------------------
    // spreader strength
    // ------------------------------------------------------------------
    // untouched default spreads only at slow clocks; an explicit
    // choice is always honoured as written
    always @* begin
        if (spr_written) begin
            eff_spr = act_spr;
        end else if (is_pll && act_mult > `PCG_SLOW_MAX_MULT) begin
            eff_spr = `PCG_SPR_OFF;
        end else begin
            eff_spr = `PCG_SPR_NORMAL;
        end
    end

    // ------------------------------------------------------------------
    // drive the analog controls from flops
    // ------------------------------------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            spread_mode <= `PCG_SPR_RESET;
            dbl_en      <= `PCG_DBL_RESET;
        end else begin
            spread_mode <= eff_spr;
            // doubler on the doubler variant follows software
            dbl_en      <= is_pll ? 1'b0 : req_dbl;
        end
    end

    // ------------------------------------------------------------------
    // applied frequency in kHz
    // ------------------------------------------------------------------
    // doubler variant: twice the crystal, or the crystal when bypassed
    always @* begin
        if (is_pll) begin
            freq_khz = {28'h0000000, act_mult} * `PCG_STEP_KHZ;
        end else if (req_dbl) begin
            freq_khz = `PCG_XTAL_KHZ + `PCG_XTAL_KHZ;
        end else begin
            freq_khz = `PCG_XTAL_KHZ;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always @* begin
        rd_mux = 32'h00000000;
        if (hit_ctrl) begin
            rd_mux[`PCG_CTRL_MULT_MSB:`PCG_CTRL_MULT_LSB] = req_mult;
            rd_mux[`PCG_CTRL_SPR_MSB:`PCG_CTRL_SPR_LSB]   = req_spr;
            rd_mux[`PCG_CTRL_DBL_BIT]                     = req_dbl;
        end else if (hit_status) begin
            rd_mux[`PCG_CTRL_MULT_MSB:`PCG_CTRL_MULT_LSB] = act_mult;
            rd_mux[`PCG_CTRL_SPR_MSB:`PCG_CTRL_SPR_LSB]   = eff_spr;
            rd_mux[`PCG_ST_BUSY_BIT]   = (state != ST_IDLE) | pending;
            rd_mux[`PCG_ST_LOCK_BIT]   = lock_sync;
            rd_mux[`PCG_ST_VAR_BIT]    = is_pll;
            rd_mux[`PCG_ST_BADSEL_BIT] = bad_sel;
        end else if (hit_freq) begin
            rd_mux = freq_khz;
        end
    end

    // read data is registered in the setup cycle, so it is stable
    // through the whole access phase
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en && !penable) begin
            prdata <= rd_mux;
        end
    end

endmodule
`default_nettype wire
